// [hdl/rtcci_pkg.sv]
// Purpose: shared constants for the calendar clock control and interrupt timer
// Assumes: 20 MHz APB clock, one aligned 32-bit word per register index
// Notes: byte address of a register is four times its index
package rtcci_pkg;

  // clock rate and the tenth-of-second time base
  localparam int unsigned CLK_HZ = 32'h0131_2d00;
  localparam int unsigned TENTH_MS = 32'h0000_0064;
  localparam int unsigned TENTH_CYCLES = CLK_HZ / 32'h0000_03e8 * TENTH_MS;

  // register indexes and byte addresses
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_SETUP = 4'hf;
  localparam logic [7:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [7:0] ADDR_SETUP = {2'h0, IDX_SETUP, 2'h0};

  // control write fields
  localparam int CTL_INT_HALT = 0;
  localparam int CTL_SELECT = 1;
  localparam int CTL_CLK_HALT = 2;
  localparam int CTL_TEST = 3;
  localparam logic [3:0] CTRL_RESET = 4'h5;

  // status read fields
  localparam int STS_IRQ = 0;
  localparam int STS_CHANGED = 3;

  // calendar_setting fields
  localparam int CAL_HOUR_MODE = 0;
  localparam int CAL_HALF_DAY = 1;
  localparam int CAL_LEAP_LSB = 2;
  localparam logic [3:0] CAL_RESET = 4'h0;

  // periodic_alarm_setup fields
  localparam int ALM_REPEAT = 3;
  localparam logic [3:0] ALM_RESET = 4'h0;
  localparam logic [2:0] DLY_NONE = 3'h0;

  localparam logic [3:0] TENTHS_MAX = 4'h9;

  // delay lengths in tenths of a second
  localparam logic [9:0] DLY_T_0S1 = 10'h001;
  localparam logic [9:0] DLY_T_0S5 = 10'h005;
  localparam logic [9:0] DLY_T_1S = 10'h00a;
  localparam logic [9:0] DLY_T_5S = 10'h032;
  localparam logic [9:0] DLY_T_10S = 10'h064;
  localparam logic [9:0] DLY_T_30S = 10'h12c;
  localparam logic [9:0] DLY_T_60S = 10'h258;

  function automatic logic [9:0] rtcci_delay_tenths(input logic [2:0] code);
    logic [9:0] t;
    t = DLY_T_0S1;
    unique case (code)
      3'h1: t = DLY_T_0S1;
      3'h2: t = DLY_T_0S5;
      3'h3: t = DLY_T_1S;
      3'h4: t = DLY_T_5S;
      3'h5: t = DLY_T_10S;
      3'h6: t = DLY_T_30S;
      3'h7: t = DLY_T_60S;
      default: t = DLY_T_0S1;
    endcase
    return t;
  endfunction

endpackage

// [hdl/rtcci_timer_if.sv]
// Purpose: link between the register block and the interrupt delay timer
// Assumes: both ends on pclk
// Notes: start is a one-cycle pulse, halt a level
`timescale 1ns/1ps
`default_nettype none
interface rtcci_timer_if;
  logic start;
  logic halt;
  logic [2:0] delay_code;
  logic repeat_mode;
  logic timeout;
  logic running;
  modport ctrl (output start, output halt, output delay_code, output repeat_mode,
                input timeout, input running);
  modport timer (input start, input halt, input delay_code, input repeat_mode,
                 output timeout, output running);
endinterface
`default_nettype wire

// [hdl/rtcci_alarm_timer.sv]
// Purpose: programmable single or repeating interrupt delay timer
// Assumes: start and halt come from the control register logic
// Notes: repeat reload is exact, so periods stay locked to the first timeout
`timescale 1ns/1ps
`default_nettype none
module rtcci_alarm_timer
  import rtcci_pkg::*;
#(
  parameter int unsigned TENTH_LEN = TENTH_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  rtcci_timer_if.timer tif
);

  typedef enum logic {RTCCI_T_IDLE, RTCCI_T_RUN} rtcci_tstate_t;

  localparam logic [21:0] PRE_LAST = 22'(TENTH_LEN - 1);

  rtcci_tstate_t state;
  logic [21:0] pre;
  logic [9:0] tenth;
  logic [9:0] last_tenth;
  logic tenth_wrap;

  assign last_tenth = rtcci_delay_tenths(tif.delay_code) - 10'h001;
  assign tenth_wrap = (pre == PRE_LAST);
  assign tif.running = (state == RTCCI_T_RUN);
  assign tif.timeout = tif.running && !tif.start && tenth_wrap && (tenth == last_tenth);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= RTCCI_T_IDLE;
    else if (tif.start)
      state <= RTCCI_T_RUN;
    else if (tif.halt)
      state <= RTCCI_T_IDLE;
    else if (tif.timeout && !tif.repeat_mode)
      state <= RTCCI_T_IDLE;
  end

  // counts restart from zero on every start, giving a full delay
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre <= 22'h000000;
      tenth <= 10'h000;
    end
    else if (tif.start || state != RTCCI_T_RUN)
    begin
      pre <= 22'h000000;
      tenth <= 10'h000;
    end
    else if (tenth_wrap)
    begin
      pre <= 22'h000000;
      tenth <= (tenth == last_tenth) ? 10'h000 : tenth + 10'h001;
    end
    else
      pre <= pre + 22'h000001;
  end

  chk_start_full_delay: assert property (@(posedge pclk) disable iff (!presetn)
    tif.start |=> (pre == 22'h000000) && (tenth == 10'h000) && tif.running)
    else $error("timer start did not clear the counts");

  chk_single_stops: assert property (@(posedge pclk) disable iff (!presetn)
    tif.timeout && !tif.repeat_mode && !tif.start |=> !tif.running)
    else $error("single mode timer kept running after timeout");

  chk_repeat_continues: assert property (@(posedge pclk) disable iff (!presetn)
    tif.timeout && tif.repeat_mode && !tif.halt |=> tif.running && tenth == 10'h000)
    else $error("repeat mode timer did not restart its period");

  chk_delay_length: assert property (@(posedge pclk) disable iff (!presetn)
    tif.timeout |-> tenth == rtcci_delay_tenths(tif.delay_code) - 10'h001)
    else $error("timeout at wrong tenth count");

endmodule
`default_nettype wire

// [hdl/rtcci_core.sv]
// Purpose: control/status, calendar setting and interrupt register block on APB
// Assumes: setting pulse and oscillator arrive as asynchronous pins
// Notes: pready is always high; index 0 and index 15 are the only mapped words
//
// Operation
// - address 0 splits into four write-only control latches and a read status view
// - address 15 shows calendar setting when select is 0, alarm setup when 1
// - calendar bit 0 is hour mode, bit 1 the half-day indicator, both R/W
// - calendar bits 3:2 are the R/W leap-year counter, zero meaning leap year
// - alarm bits 2:0 pick delays from 0.1 s up to 60 s
// - alarm bit 3 chooses single or repeating interrupts
// - delay code 000 clears the interrupt output and forces interrupt halt
// - first timeout within 1 ms; repeats stay locked to the first
// - control bit 3 set enters test mode, clear keeps normal operation
// - control bit 2 set halts timekeeping and zeroes the tenths counter
// - control bit 0 set halts and resets the timer, clear starts it
// - after new nonzero delay, timing waits for a zero interrupt halt write
// - single mode stops at timeout until halt is written zero again
// - repeat mode restarts each period with no processor action
// - halting the timer resets it so restart gives a full delay
// - status read gives changed flag on bit 3, interrupt flag on bit 0
// - only a control register read clears the changed flag
// - each timeout sets the interrupt flag and pulls the interrupt low
// - control register read clears interrupt flag and interrupt output
// - flags stay stable through the read, clearing at its trailing edge
// - timeout during a control read is kept and shown after the read
// - setting pulse during a control read leaves the changed flag alone
// - setting pulse falling edge sets the changed flag and steps time
// - test mode puts the oscillator on the interrupt pin until a delay is set
`timescale 1ns/1ps
`default_nettype none
module rtcci_core
  import rtcci_pkg::*;
#(
  parameter int unsigned TENTH_LEN = TENTH_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_in,
  input wire logic setting_pulse_in,
  output logic irq_n,
  output logic test_mode,
  output logic clock_halt,
  output logic time_tick,
  output logic [3:0] tenths_count
);

  rtcci_timer_if tif ();

  logic [1:0] pin_raw;
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_lvl;
  logic pulse_prev;
  logic setting_fall;

  logic reg_select;
  logic int_halt;
  logic [3:0] cal_setting;
  logic [3:0] alarm_setup;
  logic changed_flag;
  logic irq_flag;
  logic irq_pend;
  logic irq_line;

  logic hit_ctrl;
  logic hit_setup;
  logic setup_ph;
  logic access_ph;
  logic wr_ctrl;
  logic wr_setup;
  logic ctrl_rd_active;
  logic ctrl_rd_end;
  logic no_delay;
  logic [31:0] next_prdata;

  // pin synchronisers, a level change is taken when stages two and three agree
  assign pin_raw = {setting_pulse_in, osc_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pin
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
          pin_lvl[gi] <= 1'b0;
        end
        else
        begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi])
            pin_lvl[gi] <= pin_s3[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_prev <= 1'b0;
    else
      pulse_prev <= pin_lvl[1];
  end

  assign setting_fall = pulse_prev && !pin_lvl[1];

  // bus decode
  assign hit_ctrl = (paddr == ADDR_CTRL);
  assign hit_setup = (paddr == ADDR_SETUP);
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access_ph && !(hit_ctrl || hit_setup);
  assign wr_ctrl = access_ph && pwrite && hit_ctrl;
  assign wr_setup = access_ph && pwrite && hit_setup;
  assign ctrl_rd_active = psel && !pwrite && hit_ctrl;
  assign ctrl_rd_end = access_ph && !pwrite && hit_ctrl;
  assign no_delay = (alarm_setup[2:0] == DLY_NONE);

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit_ctrl)
    begin
      next_prdata[STS_CHANGED] = changed_flag;
      next_prdata[STS_IRQ] = irq_flag;
    end
    else if (hit_setup)
      next_prdata[3:0] = reg_select ? alarm_setup : cal_setting;
  end

  // read data is latched in the setup cycle, so it is stable through the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_ph && !pwrite)
      prdata <= next_prdata;
  end

  // control latches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      test_mode <= CTRL_RESET[CTL_TEST];
      clock_halt <= CTRL_RESET[CTL_CLK_HALT];
      reg_select <= CTRL_RESET[CTL_SELECT];
    end
    else if (wr_ctrl)
    begin
      test_mode <= pwdata[CTL_TEST];
      clock_halt <= pwdata[CTL_CLK_HALT];
      reg_select <= pwdata[CTL_SELECT];
    end
  end

  // interrupt halt: forced high with no delay programmed or on new setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_halt <= CTRL_RESET[CTL_INT_HALT];
    else if (wr_ctrl)
      int_halt <= pwdata[CTL_INT_HALT] || no_delay;
    else if (wr_setup && reg_select)
      int_halt <= 1'b1;
  end

  // address 15 registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cal_setting <= CAL_RESET;
      alarm_setup <= ALM_RESET;
    end
    else if (wr_setup)
    begin
      if (reg_select)
        alarm_setup <= pwdata[3:0];
      else
        cal_setting <= pwdata[3:0];
    end
  end

  // timer hookup
  assign tif.start = wr_ctrl && !pwdata[CTL_INT_HALT] && !no_delay;
  assign tif.halt = int_halt;
  assign tif.delay_code = alarm_setup[2:0];
  assign tif.repeat_mode = alarm_setup[ALM_REPEAT];

  rtcci_alarm_timer #(
    .TENTH_LEN(TENTH_LEN)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif)
  );

  // tenths counter and time step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tenths_count <= 4'h0;
      time_tick <= 1'b0;
    end
    else if (clock_halt)
    begin
      tenths_count <= 4'h0;
      time_tick <= 1'b0;
    end
    else
    begin
      time_tick <= setting_fall;
      if (setting_fall)
        tenths_count <= (tenths_count == TENTHS_MAX) ? 4'h0 : tenths_count + 4'h1;
    end
  end

  // changed flag: a step during a control read is dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      changed_flag <= 1'b0;
    else if (ctrl_rd_end)
      changed_flag <= 1'b0;
    else if (setting_fall && !clock_halt && !ctrl_rd_active)
      changed_flag <= 1'b1;
  end

  // timeout while a control read is open waits in irq_pend
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_pend <= 1'b0;
    else if (ctrl_rd_end)
      irq_pend <= 1'b0;
    else if (tif.timeout && ctrl_rd_active)
      irq_pend <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_flag <= 1'b0;
    else if (ctrl_rd_end)
      irq_flag <= irq_pend || tif.timeout;
    else if (tif.timeout && !ctrl_rd_active)
      irq_flag <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_line <= 1'b0;
    else if (ctrl_rd_end)
      irq_line <= irq_pend || tif.timeout;
    else if (tif.timeout && !ctrl_rd_active)
      irq_line <= 1'b1;
    else if (wr_setup && reg_select && pwdata[2:0] == DLY_NONE)
      irq_line <= 1'b0;
  end

  // pin driver: oscillator in test mode while no delay is programmed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_n <= 1'b1;
    else if (test_mode && no_delay)
      irq_n <= pin_lvl[0];
    else
      irq_n <= !irq_line;
  end

  chk_status_layout: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && !pwrite && hit_ctrl |=> prdata[31:4] == 28'h0000000 && prdata[2:1] == 2'h0)
    else $error("status read shows nonzero unused bits");

  chk_status_values: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && !pwrite && hit_ctrl |=>
      prdata[3] == $past(changed_flag) && prdata[0] == $past(irq_flag))
    else $error("status read does not show the flags");

  chk_select_map: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && !pwrite && hit_setup && reg_select |=> prdata[3:0] == $past(alarm_setup))
    else $error("index 15 read ignored the register select");

  chk_changed_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_rd_end |=> !changed_flag)
    else $error("changed flag survived a control read");

  chk_changed_write_keep: assert property (@(posedge pclk) disable iff (!presetn)
    changed_flag && psel && pwrite |=> changed_flag)
    else $error("a write cleared the changed flag");

  chk_tick_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    setting_fall && ctrl_rd_active && !changed_flag |=> !changed_flag)
    else $error("setting pulse during control read set the flag");

  chk_flags_stable: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_rd_active && !ctrl_rd_end |=> $stable(irq_flag) && $stable(changed_flag))
    else $error("status flags moved during a control read");

  chk_irq_sets: assert property (@(posedge pclk) disable iff (!presetn)
    tif.timeout && !psel && !test_mode |=> irq_flag ##1 !irq_n)
    else $error("timeout did not raise flag and pull interrupt low");

  chk_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_rd_end && !irq_pend && !tif.timeout |=> !irq_flag && !irq_line)
    else $error("control read did not clear the interrupt");

  chk_pend_release: assert property (@(posedge pclk) disable iff (!presetn)
    tif.timeout && ctrl_rd_active && !ctrl_rd_end |=> irq_pend && $stable(irq_line))
    else $error("timeout during read was lost or shown early");

  chk_no_delay: assert property (@(posedge pclk) disable iff (!presetn)
    wr_setup && reg_select && pwdata[2:0] == DLY_NONE |=> int_halt && !irq_line)
    else $error("zero delay did not halt and clear the interrupt");

  chk_tenths_halt: assert property (@(posedge pclk) disable iff (!presetn)
    clock_halt |=> tenths_count == 4'h0 && !time_tick)
    else $error("tenths counter moved while clock halted");

  chk_test_osc: assert property (@(posedge pclk) disable iff (!presetn)
    test_mode && no_delay |=> irq_n == $past(pin_lvl[0]))
    else $error("oscillator not routed in test mode");

endmodule
`default_nettype wire

// [tb/rtcci_source_model.sv]
// Purpose: oscillator and time-setting pulse source facing the clock block
// Assumes: both lines stand still unless a task moves them
// Notes: pulse width matches the oscillator-gated setting strobe
`timescale 1ns/1ps
`default_nettype none
module rtcci_source_model
#(
  parameter int PULSE_NS = 15260
)
(
  output logic osc_out,
  output logic setting_out
);
  initial
  begin
    osc_out = 1'b0;
    setting_out = 1'b0;
  end

  // one setting strobe; time moves on its fall
  task automatic pulse();
    setting_out <= 1'b1;
    #(PULSE_NS);
    setting_out <= 1'b0;
  endtask

  // oscillator held at a level, enough to see it on the interrupt pin
  task automatic osc_level(input logic v);
    osc_out <= v;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: self-checking bench for the clock control and interrupt timer
// Assumes: tenth of a second shortened to 20 clock cycles
// Notes: register rows first, then timer, flag and test mode cases
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rtcci_pkg::*;
  localparam int TL = 20;
  typedef struct {logic wr; logic [7:0] a; logic [3:0] d; logic [3:0] e;} rtcci_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_n;
  logic test_mode, clock_halt, time_tick, osc, spulse;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] tenths_count;
  int errors, comparisons, cyc, t0, t1, n, ticks;
  int tenths_tab[8] = '{0, 1, 5, 10, 50, 100, 300, 600};
  rtcci_row_t rows[12] = '{
    '{1'b1, 8'h00, 4'h7, 4'h0}, '{1'b1, 8'h3c, 4'ha, 4'h0}, '{1'b0, 8'h3c, 4'h0, 4'ha},
    '{1'b1, 8'h00, 4'h5, 4'h0}, '{1'b1, 8'h3c, 4'hd, 4'h0}, '{1'b0, 8'h3c, 4'h0, 4'hd},
    '{1'b0, 8'h04, 4'h0, 4'h0}, '{1'b1, 8'h08, 4'hf, 4'h0}, '{1'b0, 8'h3c, 4'h0, 4'hd},
    '{1'b0, 8'h00, 4'h0, 4'h0}, '{1'b1, 8'h00, 4'h7, 4'h0}, '{1'b0, 8'h3c, 4'h0, 4'ha}};

  rtcci_core #(.TENTH_LEN(TL)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_in(osc), .setting_pulse_in(spulse),
    .irq_n(irq_n), .test_mode(test_mode), .clock_halt(clock_halt), .time_tick(time_tick),
    .tenths_count(tenths_count));
  rtcci_source_model m (.osc_out(osc), .setting_out(spulse));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) cyc <= cyc + 1;

  // counts one-cycle time step pulses
  always @(posedge pclk) if (time_tick === 1'b1) ticks <= ticks + 1;

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [3:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {28'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    check("pslverr", pslverr, (a != 8'h00 && a != 8'h3c));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_irq(input int limit, output int t);
    n = 0;
    while (irq_n !== 1'b0 && n < limit)
    begin
      @(posedge pclk);
      n++;
    end
    check("irq low", irq_n, 1'b0);
    t = cyc;
  endtask

  task automatic arm(input logic [3:0] code);
    apb(1'b1, 8'h00, 4'h3);
    apb(1'b1, 8'h3c, code);
    apb(1'b1, 8'h00, 4'h2);
    t0 = cyc;
  endtask

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #3000000;
    errors++;
    print_verdict();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, cyc, errors, comparisons, ticks} = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    check("irq_n rst", irq_n, 1'b1);
    check("halt rst", {test_mode, clock_halt, tenths_count}, 6'h10);
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr)
        check("row read", rd, {28'h0, rows[i].e});
    end
    for (int c = 1; c < 8; c++)
    begin
      arm(c[3:0]);
      wait_irq(tenths_tab[c] * TL + 40, t1);
      check("delay", (t1 - t0 - tenths_tab[c] * TL) inside {[0:4]}, 1'b1);
      apb(1'b0, 8'h00, 4'h0);
      check("irq flag", rd, 32'h1);
      repeat (3) @(posedge pclk);
      check("irq cleared", irq_n, 1'b1);
      if (c == 1)
      begin
        repeat (3 * TL) @(posedge pclk);
        check("single stop", irq_n, 1'b1);
      end
    end
    arm(4'h9);
    wait_irq(3 * TL, t0);
    apb(1'b0, 8'h00, 4'h0);
    check("repeat flag", rd, 32'h1);
    repeat (3) @(posedge pclk);
    wait_irq(3 * TL, t1);
    check("repeat period", t1 - t0, TL);
    arm(4'h9);
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b0, 8'h00, 4'h0);
      check("read at timeout", rd, {31'h0, k == 0 || k == 7});
    end
    apb(1'b1, 8'h00, 4'h3);
    apb(1'b0, 8'h00, 4'h0);
    repeat (3 * TL) @(posedge pclk);
    check("halted", irq_n, 1'b1);
    arm(4'h2);
    repeat (3 * TL) @(posedge pclk);
    apb(1'b1, 8'h00, 4'h3);
    apb(1'b1, 8'h00, 4'h2);
    t0 = cyc;
    wait_irq(8 * TL, t1);
    check("full restart", (t1 - t0 - 5 * TL) inside {[0:4]}, 1'b1);
    apb(1'b0, 8'h00, 4'h0);
    check("restart flag", rd, 32'h1);
    apb(1'b1, 8'h3c, 4'h1);
    repeat (3 * TL) @(posedge pclk);
    check("no start", irq_n, 1'b1);
    apb(1'b1, 8'h00, 4'h2);
    wait_irq(3 * TL, t1);
    apb(1'b1, 8'h3c, 4'h0);
    repeat (3) @(posedge pclk);
    check("none clears", irq_n, 1'b1);
    apb(1'b1, 8'h00, 4'h2);
    apb(1'b0, 8'h00, 4'h0);
    repeat (3 * TL) @(posedge pclk);
    check("none halts", irq_n, 1'b1);
    apb(1'b1, 8'h00, 4'hb);
    m.osc_level(1'b1);
    repeat (8) @(posedge pclk);
    check("osc high", {test_mode, irq_n}, 2'h3);
    m.osc_level(1'b0);
    repeat (8) @(posedge pclk);
    check("osc low", irq_n, 1'b0);
    apb(1'b1, 8'h3c, 4'h1);
    repeat (8) @(posedge pclk);
    check("osc removed", irq_n, 1'b1);
    apb(1'b1, 8'h00, 4'h1);
    apb(1'b0, 8'h00, 4'h0);
    m.pulse();
    repeat (10) @(posedge pclk);
    check("tenths step", tenths_count, 4'h1);
    check("tick count", ticks, 32'h1);
    apb(1'b0, 8'h00, 4'h0);
    check("changed set", rd, 32'h8);
    apb(1'b0, 8'h00, 4'h0);
    check("changed cleared", rd, 32'h0);
    m.pulse();
    repeat (10) @(posedge pclk);
    apb(1'b1, 8'h00, 4'h1);
    apb(1'b0, 8'h3c, 4'h0);
    apb(1'b0, 8'h00, 4'h0);
    check("write keeps flag", rd, 32'h8);
    apb(1'b1, 8'h00, 4'h5);
    repeat (2) @(posedge pclk);
    check("clock halt", {clock_halt, tenths_count}, 5'h10);
    print_verdict();
  end
endmodule
`default_nettype wire
